/* File: timer16_pkg.sv */
package timer16_pkg;

  // byte locations on the 8-bit data bus
  localparam logic [3:0] ADDR_CTRL_FIRST   = 4'h0;
  localparam logic [3:0] ADDR_CTRL_SECOND  = 4'h1;
  localparam logic [3:0] ADDR_FLAGS        = 4'h2;
  localparam logic [3:0] ADDR_COUNT_LOW    = 4'h3;
  localparam logic [3:0] ADDR_COUNT_HIGH   = 4'h4;
  localparam logic [3:0] ADDR_CAPTURE_LOW  = 4'h5;
  localparam logic [3:0] ADDR_CAPTURE_HIGH = 4'h6;
  localparam logic [3:0] ADDR_COMPARE_LOW  = 4'h7;
  localparam logic [3:0] ADDR_COMPARE_STEP = 4'h2;
  localparam int         NUM_COMPARE       = 3;

  // field positions
  localparam int CF_WAVE_LSB   = 0;
  localparam int CF_OUTMODE_LSB = 2;
  localparam int CS_SELECT_LSB = 0;
  localparam int CS_WAVE_LSB   = 3;
  localparam int CS_AUX_LSB    = 6;
  localparam int FLAG_OVERFLOW = 0;

  // reset values
  localparam logic [7:0]  RESET_BYTE  = 8'h00;
  localparam logic [15:0] RESET_WORD  = 16'h0000;

  // count limits
  localparam logic [15:0] COUNT_FLOOR = 16'h0000;
  localparam logic [15:0] COUNT_MAX   = 16'hffff;
  localparam logic [15:0] TOP_8BIT    = 16'h00ff;
  localparam logic [15:0] TOP_9BIT    = 16'h01ff;
  localparam logic [15:0] TOP_10BIT   = 16'h03ff;

  // tick source selection
  localparam logic [2:0] SRC_NONE     = 3'h0;
  localparam logic [2:0] SRC_SYSCLK   = 3'h1;
  localparam logic [2:0] SRC_TAP_LO   = 3'h2;
  localparam logic [2:0] SRC_TAP_HI   = 3'h5;
  localparam logic [2:0] SRC_PIN_FALL = 3'h6;
  localparam logic [2:0] SRC_PIN_RISE = 3'h7;

  // waveform modes
  localparam logic [3:0] WM_NORMAL     = 4'h0;
  localparam logic [3:0] WM_PC8        = 4'h1;
  localparam logic [3:0] WM_PC9        = 4'h2;
  localparam logic [3:0] WM_PC10       = 4'h3;
  localparam logic [3:0] WM_CTC_CMP    = 4'h4;
  localparam logic [3:0] WM_FAST8      = 4'h5;
  localparam logic [3:0] WM_FAST9      = 4'h6;
  localparam logic [3:0] WM_FAST10     = 4'h7;
  localparam logic [3:0] WM_PFC_CAP    = 4'h8;
  localparam logic [3:0] WM_PFC_CMP    = 4'h9;
  localparam logic [3:0] WM_PC_CAP     = 4'ha;
  localparam logic [3:0] WM_PC_CMP     = 4'hb;
  localparam logic [3:0] WM_CTC_CAP    = 4'hc;
  localparam logic [3:0] WM_RESERVED   = 4'hd;
  localparam logic [3:0] WM_FAST_CAP   = 4'he;
  localparam logic [3:0] WM_FAST_CMP   = 4'hf;

endpackage

/* File: tick_select.sv */
`timescale 1ns/1ps
module tick_select
  import timer16_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // selection and sources
  input  wire logic [2:0] select_i,
  input  wire logic [3:0] prescale_taps_i,
  input  wire logic       ext_pin_i,
  // tick out
  output logic            tick_o
);
  import timer16_pkg::*;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic last;
    logic tick;
  } tick_state_s;

  tick_state_s state_reg;
  tick_state_s state_next;
  logic [1:0]  tap_index;

  always_comb begin
    state_next       = state_reg;
    tap_index        = 2'(select_i - SRC_TAP_LO);
    state_next.sync1 = ext_pin_i;
    state_next.sync2 = state_reg.sync1;
    state_next.last  = state_reg.sync2;
    case (select_i)
      SRC_NONE:     state_next.tick = 1'b0;
      SRC_SYSCLK:   state_next.tick = 1'b1;
      SRC_PIN_FALL: state_next.tick = state_reg.last & ~state_reg.sync2;
      SRC_PIN_RISE: state_next.tick = ~state_reg.last & state_reg.sync2;
      default: begin
        if (select_i <= SRC_TAP_HI) begin
          state_next.tick = prescale_taps_i[tap_index];
        end else begin
          state_next.tick = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick_o = state_reg.tick;

endmodule

/* File: count_unit.sv */
`timescale 1ns/1ps
module count_unit
  import timer16_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // control
  input  wire logic        load_i,
  input  wire logic [15:0] load_value_i,
  input  wire logic        tick_i,
  input  wire logic [15:0] top_i,
  input  wire logic        dual_slope_i,
  input  wire logic        clear_at_top_i,
  // state out
  output logic [15:0]      count_o,
  output logic             down_o,
  output logic             floor_o,
  output logic             ceiling_o
);
  import timer16_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic        down;
    logic        floor;
    logic        ceiling;
  } count_state_s;

  count_state_s state_reg;
  count_state_s state_next;

  always_comb begin
    state_next = state_reg;
    if (load_i) begin
      state_next.count = load_value_i;
    end else if (tick_i) begin
      if (dual_slope_i) begin
        if (!state_reg.down && state_reg.count >= top_i) begin
          state_next.down  = 1'b1;
          state_next.count = state_reg.count - 16'h0001;
        end else if (state_reg.down && state_reg.count == COUNT_FLOOR) begin
          state_next.down  = 1'b0;
          state_next.count = state_reg.count + 16'h0001;
        end else if (state_reg.down) begin
          state_next.count = state_reg.count - 16'h0001;
        end else begin
          state_next.count = state_reg.count + 16'h0001;
        end
      end else begin
        state_next.down = 1'b0;
        if (clear_at_top_i && state_reg.count == top_i) begin
          state_next.count = COUNT_FLOOR;
        end else begin
          state_next.count = state_reg.count + 16'h0001;
        end
      end
    end
    state_next.floor   = (state_next.count == COUNT_FLOOR);
    state_next.ceiling = (state_next.count == top_i);
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '{count: RESET_WORD, down: 1'b0, floor: 1'b1, ceiling: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign count_o   = state_reg.count;
  assign down_o    = state_reg.down;
  assign floor_o   = state_reg.floor;
  assign ceiling_o = state_reg.ceiling;

endmodule

/* File: timer16_byte_access_counter.sv */
// Operation
// - every 16-bit value crosses the 8-bit bus as two byte accesses
// - one shared 8-bit high-byte latch serves all wide registers
// - low-byte write loads latch and written byte together in one cycle
// - count or capture low-byte read copies the upper byte into the latch that cycle
// - compare value reads come straight from the register, latch untouched
// - latch keeps its value after a low-byte write for reuse
// - count-high location reads and writes the latch, not the counter
// - three-bit source select picks the tick; zero stops the counter
// - count stays readable and writable with or without a tick source
// - a bus write to the count beats a clear or count that cycle
// - each tick clears, increments or decrements the count per mode
// - waveform mode bits split between the first and second control
// - overflow flag sets where the mode says and requests an interrupt
// - floor indicator at zero, ceiling indicator at top
// - clear forces all sixteen count bits to zero
// - top is 0x00ff, 0x01ff, 0x03ff, first compare or capture; max 0xffff
`timescale 1ns/1ps
module timer16_byte_access_counter
  import timer16_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // 8-bit processor data bus
  input  wire logic [3:0]  bus_addr_i,
  input  wire logic [7:0]  bus_wdata_i,
  input  wire logic        bus_we_i,
  input  wire logic        bus_re_i,
  output logic [7:0]       bus_rdata_o,
  // tick sources
  input  wire logic [3:0]  prescale_taps_i,
  input  wire logic        ext_clock_pin_i,
  // capture and interrupt service
  input  wire logic        capture_strobe_i,
  input  wire logic        overflow_ack_i,
  // counter state to waveform logic
  output logic [15:0]      timer_count_o,
  output logic             count_floor_o,
  output logic             count_ceiling_o,
  output logic             overflow_flag_o,
  output logic [3:0]       waveform_mode_select_o,
  output logic [5:0]       output_mode_o,
  output logic [15:0]      compare_a_o,
  output logic [15:0]      compare_b_o,
  output logic [15:0]      compare_c_o,
  output logic [15:0]      capture_value_o
);
  import timer16_pkg::*;

  typedef struct packed {
    logic [7:0]                   temp;
    logic [7:0]                   ctrl_first;
    logic [7:0]                   ctrl_second;
    logic                         overflow;
    logic [NUM_COMPARE-1:0][15:0] compare;
    logic [15:0]                  capture;
    logic [7:0]                   rdata;
  } main_state_s;

  main_state_s state_reg;
  main_state_s state_next;

  logic [3:0]  wave_mode;
  logic [2:0]  source_select;
  logic [15:0] top_value;
  logic        dual_slope;
  logic        clear_at_top;
  logic        capture_writable;
  logic        overflow_at_max;
  logic        overflow_at_top;
  logic        count_load;
  logic        overflow_set;
  logic        tick;
  logic [15:0] count;
  logic        count_down;
  logic        floor_ind;
  logic        ceiling_ind;
  logic [7:0]  read_byte;

  // mode field split over both control registers
  assign wave_mode = {state_reg.ctrl_second[CS_WAVE_LSB +: 2],
                      state_reg.ctrl_first[CF_WAVE_LSB +: 2]};
  assign source_select = state_reg.ctrl_second[CS_SELECT_LSB +: 3];

  // top, slope and overflow point per mode
  always_comb begin
    top_value        = COUNT_MAX;
    dual_slope       = 1'b0;
    clear_at_top     = 1'b0;
    capture_writable = 1'b0;
    overflow_at_max  = 1'b0;
    overflow_at_top  = 1'b0;
    case (wave_mode)
      WM_NORMAL: begin
        overflow_at_max = 1'b1;
      end
      WM_PC8: begin
        top_value  = TOP_8BIT;
        dual_slope = 1'b1;
      end
      WM_PC9: begin
        top_value  = TOP_9BIT;
        dual_slope = 1'b1;
      end
      WM_PC10: begin
        top_value  = TOP_10BIT;
        dual_slope = 1'b1;
      end
      WM_CTC_CMP: begin
        top_value       = state_reg.compare[0];
        clear_at_top    = 1'b1;
        overflow_at_max = 1'b1;
      end
      WM_FAST8: begin
        top_value       = TOP_8BIT;
        clear_at_top    = 1'b1;
        overflow_at_top = 1'b1;
      end
      WM_FAST9: begin
        top_value       = TOP_9BIT;
        clear_at_top    = 1'b1;
        overflow_at_top = 1'b1;
      end
      WM_FAST10: begin
        top_value       = TOP_10BIT;
        clear_at_top    = 1'b1;
        overflow_at_top = 1'b1;
      end
      WM_PFC_CAP, WM_PC_CAP: begin
        top_value        = state_reg.capture;
        dual_slope       = 1'b1;
        capture_writable = 1'b1;
      end
      WM_PFC_CMP, WM_PC_CMP: begin
        top_value  = state_reg.compare[0];
        dual_slope = 1'b1;
      end
      WM_CTC_CAP: begin
        top_value        = state_reg.capture;
        clear_at_top     = 1'b1;
        overflow_at_max  = 1'b1;
        capture_writable = 1'b1;
      end
      WM_FAST_CAP: begin
        top_value        = state_reg.capture;
        clear_at_top     = 1'b1;
        overflow_at_top  = 1'b1;
        capture_writable = 1'b1;
      end
      WM_FAST_CMP: begin
        top_value       = state_reg.compare[0];
        clear_at_top    = 1'b1;
        overflow_at_top = 1'b1;
      end
      default: begin
        overflow_at_max = 1'b1;
      end
    endcase
  end

  // count write through the low location, any source state
  assign count_load = bus_we_i && (bus_addr_i == ADDR_COUNT_LOW);

  // overflow event on the tick that leaves the mode's overflow point
  always_comb begin
    overflow_set = 1'b0;
    if (tick && !count_load) begin
      if (dual_slope) begin
        overflow_set = count_down && (count == COUNT_FLOOR);
      end else if (overflow_at_top) begin
        overflow_set = (count == top_value);
      end else if (overflow_at_max) begin
        overflow_set = (count == COUNT_MAX);
      end
    end
  end

  // read mux; count and capture give low byte or latch, compare bytes come from the register
  always_comb begin
    read_byte = RESET_BYTE;
    case (bus_addr_i)
      ADDR_CTRL_FIRST:   read_byte = state_reg.ctrl_first;
      ADDR_CTRL_SECOND:  read_byte = state_reg.ctrl_second;
      ADDR_FLAGS:        read_byte = {7'h00, state_reg.overflow};
      ADDR_COUNT_LOW:    read_byte = count[7:0];
      ADDR_COUNT_HIGH:   read_byte = state_reg.temp;
      ADDR_CAPTURE_LOW:  read_byte = state_reg.capture[7:0];
      ADDR_CAPTURE_HIGH: read_byte = state_reg.temp;
      default: begin
        for (int i = 0; i < NUM_COMPARE; i++) begin
          if (bus_addr_i == 4'(ADDR_COMPARE_LOW + i * ADDR_COMPARE_STEP)) begin
            read_byte = state_reg.compare[i][7:0];
          end
          if (bus_addr_i == 4'(ADDR_COMPARE_LOW + i * ADDR_COMPARE_STEP + 1)) begin
            read_byte = state_reg.compare[i][15:8];
          end
        end
      end
    endcase
  end

  // register updates
  always_comb begin
    state_next = state_reg;
    if (bus_re_i) begin
      state_next.rdata = read_byte;
      if (bus_addr_i == ADDR_COUNT_LOW) begin
        state_next.temp = count[15:8];
      end
      if (bus_addr_i == ADDR_CAPTURE_LOW) begin
        state_next.temp = state_reg.capture[15:8];
      end
    end
    if (capture_strobe_i && !capture_writable) begin
      state_next.capture = count;
    end
    if (bus_we_i) begin
      case (bus_addr_i)
        ADDR_CTRL_FIRST: begin
          state_next.ctrl_first = bus_wdata_i;
        end
        ADDR_CTRL_SECOND: begin
          state_next.ctrl_second = bus_wdata_i & 8'hdf;
        end
        ADDR_COUNT_HIGH, ADDR_CAPTURE_HIGH: begin
          state_next.temp = bus_wdata_i;
        end
        ADDR_CAPTURE_LOW: begin
          if (capture_writable) begin
            state_next.capture = {state_reg.temp, bus_wdata_i};
          end
        end
        default: begin
          for (int i = 0; i < NUM_COMPARE; i++) begin
            if (bus_addr_i == 4'(ADDR_COMPARE_LOW + i * ADDR_COMPARE_STEP)) begin
              state_next.compare[i] = {state_reg.temp, bus_wdata_i};
            end
            if (bus_addr_i == 4'(ADDR_COMPARE_LOW + i * ADDR_COMPARE_STEP + 1)) begin
              state_next.temp = bus_wdata_i;
            end
          end
        end
      endcase
    end
    if (bus_we_i && bus_addr_i == ADDR_FLAGS && bus_wdata_i[FLAG_OVERFLOW]) begin
      state_next.overflow = 1'b0;
    end
    if (overflow_ack_i) begin
      state_next.overflow = 1'b0;
    end
    if (overflow_set) begin
      state_next.overflow = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  tick_select u_tick_select (
    .sys_clk_i       (sys_clk_i),
    .rst_n_i         (rst_n_i),
    .select_i        (source_select),
    .prescale_taps_i (prescale_taps_i),
    .ext_pin_i       (ext_clock_pin_i),
    .tick_o          (tick)
  );

  count_unit u_count_unit (
    .sys_clk_i      (sys_clk_i),
    .rst_n_i        (rst_n_i),
    .load_i         (count_load),
    .load_value_i   ({state_reg.temp, bus_wdata_i}),
    .tick_i         (tick),
    .top_i          (top_value),
    .dual_slope_i   (dual_slope),
    .clear_at_top_i (clear_at_top),
    .count_o        (count),
    .down_o         (count_down),
    .floor_o        (floor_ind),
    .ceiling_o      (ceiling_ind)
  );

  // outputs
  assign bus_rdata_o            = state_reg.rdata;
  assign timer_count_o          = count;
  assign count_floor_o          = floor_ind;
  assign count_ceiling_o        = ceiling_ind;
  assign overflow_flag_o        = state_reg.overflow;
  assign waveform_mode_select_o = wave_mode;
  assign output_mode_o          = state_reg.ctrl_first[CF_OUTMODE_LSB +: 6];
  assign compare_a_o            = state_reg.compare[0];
  assign compare_b_o            = state_reg.compare[1];
  assign compare_c_o            = state_reg.compare[2];
  assign capture_value_o        = state_reg.capture;

endmodule

/* File: timer16_byte_access_counter_assertions.sv */
`timescale 1ns/1ps
module timer16_byte_access_counter_assertions
  import timer16_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // bus
  input wire logic [3:0]  bus_addr_i,
  input wire logic [7:0]  bus_wdata_i,
  input wire logic        bus_we_i,
  input wire logic        bus_re_i,
  input wire logic [7:0]  bus_rdata_o,
  // counter state
  input wire logic [15:0] timer_count_o,
  input wire logic        count_floor_o,
  input wire logic        count_ceiling_o,
  input wire logic        overflow_flag_o,
  input wire logic [3:0]  waveform_mode_select_o,
  input wire logic [15:0] compare_a_o
);
  logic [2:0] sel_reg;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // shadow of the tick source select
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sel_reg <= SRC_NONE;
    end else if (bus_we_i && bus_addr_i == ADDR_CTRL_SECOND) begin
      sel_reg <= bus_wdata_i[CS_SELECT_LSB +: 3];
    end
  end

  function automatic logic [15:0] fixed_top(input logic [3:0] m);
    case (m)
      WM_NORMAL, WM_RESERVED: fixed_top = COUNT_MAX;
      WM_PC8, WM_FAST8:       fixed_top = TOP_8BIT;
      WM_PC9, WM_FAST9:       fixed_top = TOP_9BIT;
      WM_PC10, WM_FAST10:     fixed_top = TOP_10BIT;
      default:                fixed_top = COUNT_FLOOR;
    endcase
  endfunction

  sequence hi_then_lo;
    bus_we_i && bus_addr_i == ADDR_COUNT_HIGH ##1 bus_we_i && bus_addr_i == ADDR_COUNT_LOW;
  endsequence
  sequence cmp_hi_then_cnt_rd;
    bus_we_i && bus_addr_i == ADDR_COMPARE_LOW + 4'h1 ##1 bus_re_i && !bus_we_i && bus_addr_i == ADDR_COUNT_HIGH;
  endsequence
  sequence steady_sel(logic [2:0] s);
    sel_reg == s && $past(sel_reg) == s && $past(sel_reg, 2) == s && !$past(bus_we_i);
  endsequence

  chk_low_read_byte: assert property (bus_re_i && bus_addr_i == ADDR_COUNT_LOW |=> bus_rdata_o == $past(timer_count_o[7:0]))
    else $error("count low read returned a wrong byte");
  chk_low_write_load: assert property (hi_then_lo |=> timer_count_o == {$past(bus_wdata_i, 2), $past(bus_wdata_i)})
    else $error("count not loaded from latch and low byte");
  chk_shared_latch: assert property (cmp_hi_then_cnt_rd |=> bus_rdata_o == $past(bus_wdata_i, 2))
    else $error("count high read did not return the shared latch");
  chk_compare_direct: assert property (bus_re_i && bus_addr_i == ADDR_COMPARE_LOW + 4'h1 |=> bus_rdata_o == $past(compare_a_o[15:8]))
    else $error("compare high read not taken from the register");
  chk_stopped_hold: assert property (steady_sel(SRC_NONE) |-> $stable(timer_count_o))
    else $error("count moved with no tick source");
  chk_count_step: assert property (steady_sel(SRC_SYSCLK) ##0 (waveform_mode_select_o == WM_NORMAL && $past(waveform_mode_select_o) == WM_NORMAL) |-> timer_count_o == $past(timer_count_o) + 16'h0001)
    else $error("normal count did not step by one");
  chk_overflow_wrap: assert property (steady_sel(SRC_SYSCLK) ##0 (waveform_mode_select_o == WM_NORMAL && $past(timer_count_o) == COUNT_MAX) |-> overflow_flag_o)
    else $error("overflow flag not set on wrap");
  chk_floor_match: assert property (count_floor_o == (timer_count_o == COUNT_FLOOR))
    else $error("floor indicator wrong");
  chk_ceiling_top: assert property (fixed_top(waveform_mode_select_o) != COUNT_FLOOR && $stable(waveform_mode_select_o) |-> count_ceiling_o == (timer_count_o == fixed_top(waveform_mode_select_o)))
    else $error("ceiling indicator wrong for fixed top");
endmodule

bind timer16_byte_access_counter timer16_byte_access_counter_assertions timer16_byte_access_counter_assertions_i (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
  .bus_we_i(bus_we_i), .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o), .timer_count_o(timer_count_o),
  .count_floor_o(count_floor_o), .count_ceiling_o(count_ceiling_o), .overflow_flag_o(overflow_flag_o),
  .waveform_mode_select_o(waveform_mode_select_o), .compare_a_o(compare_a_o));

/* File: cpu_model.sv */
`timescale 1ns/1ps
module cpu_model (
  // clock
  input  wire logic       sys_clk_i,
  // 8-bit data bus
  input  wire logic [7:0] bus_rdata_i,
  output logic [3:0]      bus_addr_o,
  output logic [7:0]      bus_wdata_o,
  output logic            bus_we_o,
  output logic            bus_re_o
);
  logic chained = 1'b0;
  initial begin
    bus_addr_o = 4'h0;
    bus_wdata_o = 8'h00;
    bus_we_o = 1'b0;
    bus_re_o = 1'b0;
  end
  // one byte cycle taken at the rising edge; keep chains the next one back to back
  task automatic cyc(input logic we, input logic re, input logic [3:0] a, input logic [7:0] d, input bit keep,
                     output logic [7:0] q);
    if (!chained) begin
      @(negedge sys_clk_i);
    end
    bus_we_o = we;
    bus_re_o = re;
    bus_addr_o = a;
    bus_wdata_o = d;
    @(negedge sys_clk_i);
    q = bus_rdata_i;
    chained = keep;
    if (!keep) begin
      bus_we_o = 1'b0;
      bus_re_o = 1'b0;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    cyc(1'b1, 1'b0, a, d, 1'b0, q);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] q);
    cyc(1'b0, 1'b1, a, ~bus_wdata_o, 1'b0, q);
  endtask
  // released bus shows a changing pattern
  task automatic idle();
    @(negedge sys_clk_i);
    bus_we_o = 1'b0;
    bus_re_o = 1'b0;
    bus_wdata_o = ~bus_wdata_o;
  endtask
  // wide accesses run back to back, never interleaved with others
  task automatic wr16(input logic [3:0] lo, input logic [15:0] v);
    logic [7:0] q;
    cyc(1'b1, 1'b0, lo + 4'h1, v[15:8], 1'b1, q);
    cyc(1'b1, 1'b0, lo, v[7:0], 1'b0, q);
  endtask
  task automatic rd16(input logic [3:0] lo, output logic [15:0] v);
    cyc(1'b0, 1'b1, lo, ~bus_wdata_o, 1'b1, v[7:0]);
    cyc(1'b0, 1'b1, lo + 4'h1, ~bus_wdata_o, 1'b0, v[15:8]);
  endtask
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import timer16_pkg::*;
  logic        sys_clk_i;
  logic        rst_n_i;
  logic [3:0]  bus_addr_i;
  logic [7:0]  bus_wdata_i;
  logic        bus_we_i;
  logic        bus_re_i;
  logic [7:0]  bus_rdata_o;
  logic [3:0]  prescale_taps_i;
  logic        ext_clock_pin_i;
  logic        capture_strobe_i;
  logic        overflow_ack_i;
  logic [15:0] timer_count_o;
  logic        count_floor_o;
  logic        count_ceiling_o;
  logic        overflow_flag_o;
  logic [3:0]  waveform_mode_select_o;
  logic [15:0] compare_a_o;
  logic [15:0] compare_b_o;
  logic [15:0] capture_value_o;
  logic [15:0] q;
  logic [15:0] c0;
  logic [7:0]  b;
  int          n_errors;
  int          total_checks;

  timer16_byte_access_counter timer16_byte_access_counter_i (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_we_i(bus_we_i), .bus_re_i(bus_re_i), .bus_rdata_o(bus_rdata_o), .prescale_taps_i(prescale_taps_i),
    .ext_clock_pin_i(ext_clock_pin_i), .capture_strobe_i(capture_strobe_i), .overflow_ack_i(overflow_ack_i),
    .timer_count_o(timer_count_o), .count_floor_o(count_floor_o), .count_ceiling_o(count_ceiling_o),
    .overflow_flag_o(overflow_flag_o), .waveform_mode_select_o(waveform_mode_select_o), .output_mode_o(),
    .compare_a_o(compare_a_o), .compare_b_o(compare_b_o), .compare_c_o(), .capture_value_o(capture_value_o));
  cpu_model cpu_model_i (
    .sys_clk_i(sys_clk_i), .bus_rdata_i(bus_rdata_o), .bus_addr_o(bus_addr_i), .bus_wdata_o(bus_wdata_i),
    .bus_we_o(bus_we_i), .bus_re_o(bus_re_i));

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e) begin
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
      n_errors++;
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge sys_clk_i);
  endtask
  task automatic set_mode(input logic [3:0] m, input logic [2:0] s);
    cpu_model_i.wr(ADDR_CTRL_FIRST, {6'h00, m[1:0]});
    cpu_model_i.wr(ADDR_CTRL_SECOND, {3'h0, m[3:2], s});
  endtask
  // load while stopped, then run from the system clock until the top
  task automatic run_to_top(input logic [3:0] m, input logic [15:0] v);
    set_mode(WM_NORMAL, SRC_NONE);
    cpu_model_i.wr16(ADDR_COUNT_LOW, v);
    set_mode(m, SRC_SYSCLK);
    for (int i = 0; i < 300 && count_ceiling_o !== 1'b1; i++) @(negedge sys_clk_i);
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_errors++;
    give_verdict();
  end

  initial begin
    rst_n_i = 1'b0;
    prescale_taps_i = 4'h0;
    ext_clock_pin_i = 1'b0;
    capture_strobe_i = 1'b0;
    overflow_ack_i = 1'b0;
    n_errors = 0;
    total_checks = 0;
    cycles(20);
    rst_n_i = 1'b1;
    chk({15'h0000, count_floor_o}, 16'h0001);
    cpu_model_i.rd(ADDR_CTRL_SECOND, b);
    chk({8'h00, b}, {8'h00, RESET_BYTE});
    cpu_model_i.wr16(ADDR_COUNT_LOW, 16'h01ff);
    chk(timer_count_o, 16'h01ff);
    cycles(5);
    chk(timer_count_o, 16'h01ff);
    cpu_model_i.wr(ADDR_COUNT_HIGH, 8'h55);
    chk(timer_count_o, 16'h01ff);
    cpu_model_i.rd(ADDR_COUNT_HIGH, b);
    chk({8'h00, b}, 16'h0055);
    cpu_model_i.rd16(ADDR_COUNT_LOW, q);
    chk(q, 16'h01ff);
    cpu_model_i.cyc(1'b1, 1'b0, ADDR_COMPARE_LOW + 4'h1, 8'h12, 1'b1, b);
    cpu_model_i.rd(ADDR_COUNT_HIGH, b);
    chk({8'h00, b}, 16'h0012);
    cpu_model_i.wr(ADDR_COMPARE_LOW, 8'h34);
    cpu_model_i.wr(ADDR_COMPARE_LOW + ADDR_COMPARE_STEP, 8'h56);
    chk(compare_a_o, 16'h1234);
    chk(compare_b_o, 16'h1256);
    cpu_model_i.rd(ADDR_COUNT_LOW, b);
    cpu_model_i.rd(ADDR_COMPARE_LOW + ADDR_COMPARE_STEP + 4'h1, b);
    chk({8'h00, b}, 16'h0012);
    cpu_model_i.rd(ADDR_COUNT_HIGH, b);
    chk({8'h00, b}, 16'h0001);
    cpu_model_i.rd16(ADDR_COMPARE_LOW, q);
    chk(q, 16'h1234);
    cpu_model_i.rd(4'hf, b);
    chk({8'h00, b}, 16'h0000);
    cpu_model_i.idle();
    capture_strobe_i = 1'b1;
    cycles(1);
    capture_strobe_i = 1'b0;
    chk(capture_value_o, 16'h01ff);
    cpu_model_i.rd16(ADDR_CAPTURE_LOW, q);
    chk(q, 16'h01ff);
    // wrap in normal mode
    cpu_model_i.wr16(ADDR_COUNT_LOW, 16'hfffd);
    set_mode(WM_NORMAL, SRC_SYSCLK);
    for (int i = 0; i < 10 && overflow_flag_o !== 1'b1; i++) @(negedge sys_clk_i);
    chk(timer_count_o, COUNT_FLOOR);
    cpu_model_i.wr16(ADDR_COUNT_LOW, 16'h1000);
    chk(timer_count_o, 16'h1000);
    cycles(1);
    chk(timer_count_o, 16'h1001);
    set_mode(WM_NORMAL, SRC_NONE);
    cpu_model_i.wr(ADDR_FLAGS, 8'h01);
    chk({15'h0000, overflow_flag_o}, 16'h0000);
    // prescaler taps: only the chosen one may count
    for (int k = 0; k < 4; k++) begin
      set_mode(WM_NORMAL, SRC_TAP_LO + 3'(k));
      cycles(3);
      c0 = timer_count_o;
      prescale_taps_i = ~(4'h1 << k);
      cycles(4);
      prescale_taps_i = 4'h0;
      cycles(4);
      chk(timer_count_o, c0);
      prescale_taps_i = 4'h1 << k;
      cycles(4);
      prescale_taps_i = 4'h0;
      cycles(4);
      chk(timer_count_o, c0 + 16'h0004);
    end
    // external pin: three rising and two falling edges
    for (int s = 6; s < 8; s++) begin
      set_mode(WM_NORMAL, 3'(s));
      cpu_model_i.idle();
      cycles(6);
      c0 = timer_count_o;
      repeat (3) begin
        ext_clock_pin_i = 1'b0;
        cycles(4);
        ext_clock_pin_i = 1'b1;
        cycles(4);
      end
      cycles(6);
      chk(timer_count_o, c0 + ((s == 7) ? 16'h0003 : 16'h0002));
      set_mode(WM_NORMAL, SRC_NONE);
      ext_clock_pin_i = 1'b0;
      cycles(6);
    end
    run_to_top(WM_FAST8, 16'h00fd);
    chk({12'h000, waveform_mode_select_o}, {12'h000, WM_FAST8});
    chk(timer_count_o, TOP_8BIT);
    cycles(1);
    chk(timer_count_o, COUNT_FLOOR);
    chk({15'h0000, overflow_flag_o}, 16'h0001);
    overflow_ack_i = 1'b1;
    cycles(1);
    overflow_ack_i = 1'b0;
    cycles(1);
    chk({15'h0000, overflow_flag_o}, 16'h0000);
    run_to_top(WM_PC9, 16'h01fd);
    chk(timer_count_o, TOP_9BIT);
    cycles(1);
    chk(timer_count_o, 16'h01fe);
    cpu_model_i.idle();
    give_verdict();
  end
endmodule
